// >>> flash_i2c_pkg.sv
// constants, types and register map of the two-wire register slave
// assumes a single 125 MHz clock and synchronous active-high reset
//
// What this block does
// - serial port works up to 400 kHz; the bench master clocks at 6.25 MHz
// - data changes only while clock low, except start and stop
// - first byte is seven-bit address plus direction; answer only own address
// - on address match, acknowledge on ninth clock then perform operation
// - second write byte is register address, msb first, loaded into pointer
// - acknowledge every received byte: own address, register address and data
// - advance five-bit pointer by one after each written data byte
// - burst write pointer wraps from 0x0b back to 0x00
// - read sends next register on master acknowledge, pointer advances each byte
// - burst read pointer wraps from 0x06 back to 0x00
// - stop driving read data once master withholds acknowledge and stops
// - writes other than the key register ignored until unlock pattern loaded
// - both channel bits zero powers down, else the set channels turn on
package flash_i2c_pkg;

    // bus address and pointer geometry
    localparam logic [6:0] DEV_ADDR      = 7'h37;
    localparam int         PTR_W         = 5;
    localparam logic [4:0] PTR_FIRST     = 5'h00;
    localparam logic [4:0] WR_WRAP_LAST  = 5'h0b;
    localparam logic [4:0] RD_WRAP_LAST  = 5'h06;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT   = 4'h7;
    localparam logic [3:0] CNT_ZERO      = 4'h0;

    // register offsets
    localparam logic [4:0] REG_KEY     = 5'h00;
    localparam logic [4:0] REG_CHAN    = 5'h01;
    localparam logic [4:0] REG_TIMING  = 5'h02;
    localparam logic [4:0] REG_CURRENT = 5'h03;
    localparam logic [4:0] REG_PROT    = 5'h04;
    localparam logic [4:0] REG_TRIG    = 5'h05;
    localparam logic [4:0] REG_FAULT   = 5'h06;
    localparam int         NUM_RW      = 6;

    // field positions and values
    localparam int         CH_ONE_BIT     = 0;
    localparam int         CH_TWO_BIT     = 1;
    localparam logic [7:0] UNLOCK_PATTERN = 8'h69;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;

    // reset values, listed from index 5 down to index 0
    localparam logic [NUM_RW-1:0][7:0] REG_RESET = {
        8'h00, 8'h02, 8'h0c, 8'h07, 8'h00, 8'h00};

    typedef enum {st_idle, st_rx, st_ack, st_tx, st_mack} xfer_state_t;
    typedef enum {ph_dev, ph_reg, ph_data} byte_phase_t;

endpackage

// >>> line_events_if.sv
// events found on the two bus lines, passed from sampler to engine
// assumes both ends run on the same clk
`timescale 1ns/1ps
interface line_events_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda_bit;

    modport sampler (output scl_rise, output scl_fall, output start, output stop,
                     output sda_bit);
    modport engine  (input scl_rise, input scl_fall, input start, input stop,
                     input sda_bit);
endinterface // line_events_if

// >>> line_sampler.sv
// synchronises the bus pins and finds clock edges, start and stop
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
module line_sampler (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           reset,
    // bus pins
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    // events
    line_events_if.sampler      ev
);
    // stage 1 meta, stage 2 stable, stage 3 previous for edges
    logic [2:0] scl_r, scl_nxt;
    logic [2:0] sda_r, sda_nxt;

    // shift chains
    always_comb begin
        scl_nxt = {scl_r[1:0], scl_in};
        sda_nxt = {sda_r[1:0], sda_in};
    end

    // idle bus is high on both lines
    always_ff @(posedge clk) begin
        if (reset) begin
            scl_r <= 3'h7;
            sda_r <= 3'h7;
        end else begin
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
        end
    end

    // 125 MHz gives over 300 samples per 400 kHz clock period
    assign ev.scl_rise = scl_r[1] & ~scl_r[2];
    assign ev.scl_fall = ~scl_r[1] & scl_r[2];
    assign ev.start    = scl_r[1] & scl_r[2] & ~sda_r[1] & sda_r[2];
    assign ev.stop     = scl_r[1] & scl_r[2] & sda_r[1] & ~sda_r[2];
    assign ev.sda_bit  = sda_r[1];

    // one clock level per cycle, so both edges can never coincide
    edge_excl_a: assert property (@(posedge clk) disable iff (reset)
        !(ev.scl_rise && ev.scl_fall))
        else $error("clock rise and fall seen together");
    start_seen_a: assert property (@(posedge clk) disable iff (reset)
        ev.start |-> $past(ev.sda_bit) && !ev.sda_bit)
        else $error("start without falling data");
endmodule // line_sampler

// >>> flash_i2c_slave.sv
// two-wire register slave for the flash driver control registers
// assumes an open-drain bus with external pull-ups and a fault status input
`timescale 1ns/1ps
module flash_i2c_slave (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_o,
    output logic            sda_oe,
    // analog fault status
    input  wire logic [7:0] fault_status,
    // control outputs
    output logic            channel_one_on,
    output logic            channel_two_on,
    output logic            power_down,
    output logic [7:0]      timing_cfg,
    output logic [7:0]      current_cfg,
    output logic [7:0]      protect_cfg,
    output logic [7:0]      trigger_cfg
);
    line_events_if ev ();

    line_sampler u_sampler (
        .clk    (clk),
        .reset  (reset),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .ev     (ev.sampler)
    );

    flash_i2c_pkg::xfer_state_t          state_r, state_nxt;
    flash_i2c_pkg::byte_phase_t          phase_r, phase_nxt;
    logic [3:0]                          cnt_r, cnt_nxt;
    logic [7:0]                          shift_r, shift_nxt;
    logic [4:0]                          ptr_r, ptr_nxt;
    logic                                rw_r, rw_nxt;
    logic                                oe_r, oe_nxt;
    logic                                mack_r, mack_nxt;
    logic [flash_i2c_pkg::NUM_RW-1:0][7:0] regs_r, regs_nxt;
    logic [7:0]                          fault_s1_r, fault_r;
    logic                                unlocked;
    logic                                wr_fire;
    logic                                tx_load;

    // pointer steps with separate wrap points for write and read
    // a pointer parked past its wrap point falls straight back to the first register
    function automatic logic [4:0] wr_next(input logic [4:0] p);
        wr_next = (p >= flash_i2c_pkg::WR_WRAP_LAST) ? flash_i2c_pkg::PTR_FIRST
                                                     : p + 5'h01;
    endfunction

    function automatic logic [4:0] rd_next(input logic [4:0] p);
        rd_next = (p >= flash_i2c_pkg::RD_WRAP_LAST) ? flash_i2c_pkg::PTR_FIRST
                                                     : p + 5'h01;
    endfunction

    // read decode, used for first and following read bytes
    function automatic logic [7:0] read_reg(input logic [4:0] p,
            input logic [flash_i2c_pkg::NUM_RW-1:0][7:0] r, input logic [7:0] f);
        if (p < flash_i2c_pkg::REG_FAULT)
            read_reg = r[p[2:0]];
        else if (p == flash_i2c_pkg::REG_FAULT)
            read_reg = f;
        else
            read_reg = flash_i2c_pkg::ZERO_BYTE;
    endfunction

    // key register is always writable; the rest wait for the pattern
    assign unlocked = (regs_r[flash_i2c_pkg::REG_KEY[2:0]] == flash_i2c_pkg::UNLOCK_PATTERN);

    // transfer engine next state
    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        ptr_nxt   = ptr_r;
        rw_nxt    = rw_r;
        oe_nxt    = oe_r;
        mack_nxt  = mack_r;
        regs_nxt  = regs_r;
        wr_fire   = 1'b0;
        tx_load   = 1'b0;
        if (ev.start) begin
            // repeated start keeps the pointer for random reads
            state_nxt = flash_i2c_pkg::st_rx;
            phase_nxt = flash_i2c_pkg::ph_dev;
            cnt_nxt   = flash_i2c_pkg::CNT_ZERO;
            oe_nxt    = 1'b0;
        end else if (ev.stop) begin
            state_nxt = flash_i2c_pkg::st_idle;
            oe_nxt    = 1'b0;
        end else begin
            case (state_r)
                flash_i2c_pkg::st_rx: begin
                    if (ev.scl_rise && cnt_r != flash_i2c_pkg::BITS_PER_BYTE) begin
                        // sampled on the rise, where data is steady
                        shift_nxt = {shift_r[6:0], ev.sda_bit};
                        cnt_nxt   = cnt_r + 4'h1;
                    end else if (ev.scl_fall && cnt_r == flash_i2c_pkg::BITS_PER_BYTE) begin
                        cnt_nxt   = flash_i2c_pkg::CNT_ZERO;
                        oe_nxt    = 1'b1;
                        state_nxt = flash_i2c_pkg::st_ack;
                        case (phase_r)
                            flash_i2c_pkg::ph_dev: begin
                                if (shift_r[7:1] == flash_i2c_pkg::DEV_ADDR) begin
                                    rw_nxt = shift_r[0];
                                end else begin
                                    oe_nxt    = 1'b0;
                                    state_nxt = flash_i2c_pkg::st_idle;
                                end
                            end
                            flash_i2c_pkg::ph_reg: begin
                                ptr_nxt = shift_r[4:0];
                            end
                            default: begin
                                wr_fire = 1'b1;
                                ptr_nxt = wr_next(ptr_r);
                                if (ptr_r < flash_i2c_pkg::REG_FAULT &&
                                    (ptr_r == flash_i2c_pkg::REG_KEY || unlocked))
                                    regs_nxt[ptr_r[2:0]] = shift_r;
                            end
                        endcase
                    end
                end
                flash_i2c_pkg::st_ack: begin
                    // hold the acknowledge through the ninth clock
                    if (ev.scl_fall) begin
                        oe_nxt = 1'b0;
                        if (phase_r == flash_i2c_pkg::ph_dev && rw_r) begin
                            tx_load = 1'b1;
                        end else begin
                            state_nxt = flash_i2c_pkg::st_rx;
                            phase_nxt = (phase_r == flash_i2c_pkg::ph_dev) ?
                                        flash_i2c_pkg::ph_reg : flash_i2c_pkg::ph_data;
                        end
                    end
                end
                flash_i2c_pkg::st_tx: begin
                    if (ev.scl_fall) begin
                        if (cnt_r == flash_i2c_pkg::LAST_TX_BIT) begin
                            oe_nxt    = 1'b0;
                            cnt_nxt   = flash_i2c_pkg::CNT_ZERO;
                            state_nxt = flash_i2c_pkg::st_mack;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_nxt    = ~shift_r[6];
                            cnt_nxt   = cnt_r + 4'h1;
                        end
                    end
                end
                flash_i2c_pkg::st_mack: begin
                    if (ev.scl_rise) begin
                        mack_nxt = ~ev.sda_bit;
                    end else if (ev.scl_fall) begin
                        if (mack_r)
                            tx_load = 1'b1;
                        else
                            state_nxt = flash_i2c_pkg::st_idle;
                    end
                end
                default: begin
                    oe_nxt = 1'b0;
                end
            endcase
            // load a read byte and drive its msb at once
            // pointer moves on every load, so a byte refused by nack still counts
            if (tx_load) begin
                shift_nxt = read_reg(ptr_r, regs_r, fault_r);
                oe_nxt    = ~shift_nxt[7];
                ptr_nxt   = rd_next(ptr_r);
                cnt_nxt   = flash_i2c_pkg::CNT_ZERO;
                state_nxt = flash_i2c_pkg::st_tx;
            end
        end
    end

    // engine registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= flash_i2c_pkg::st_idle;
            phase_r <= flash_i2c_pkg::ph_dev;
            cnt_r   <= flash_i2c_pkg::CNT_ZERO;
            shift_r <= flash_i2c_pkg::ZERO_BYTE;
            ptr_r   <= flash_i2c_pkg::PTR_FIRST;
            rw_r    <= 1'b0;
            oe_r    <= 1'b0;
            mack_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            ptr_r   <= ptr_nxt;
            rw_r    <= rw_nxt;
            oe_r    <= oe_nxt;
            mack_r  <= mack_nxt;
        end
    end

    // register storage, one flop group per register
    genvar gi;
    generate
        for (gi = 0; gi < flash_i2c_pkg::NUM_RW; gi++) begin : g_reg
            always_ff @(posedge clk) begin
                if (reset)
                    regs_r[gi] <= flash_i2c_pkg::REG_RESET[gi];
                else
                    regs_r[gi] <= regs_nxt[gi];
            end
        end
    endgenerate

    // fault inputs come from analog, two flops before use
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_s1_r <= flash_i2c_pkg::ZERO_BYTE;
            fault_r    <= flash_i2c_pkg::ZERO_BYTE;
        end else begin
            fault_s1_r <= fault_status;
            fault_r    <= fault_s1_r;
        end
    end

    // open drain: only ever pulls low
    assign sda_o  = 1'b0;
    assign sda_oe = oe_r;

    // channel decode straight from register flops
    assign channel_one_on = regs_r[flash_i2c_pkg::REG_CHAN[2:0]][flash_i2c_pkg::CH_ONE_BIT];
    assign channel_two_on = regs_r[flash_i2c_pkg::REG_CHAN[2:0]][flash_i2c_pkg::CH_TWO_BIT];
    assign power_down     = ~(channel_one_on | channel_two_on);
    assign timing_cfg     = regs_r[flash_i2c_pkg::REG_TIMING[2:0]];
    assign current_cfg    = regs_r[flash_i2c_pkg::REG_CURRENT[2:0]];
    assign protect_cfg    = regs_r[flash_i2c_pkg::REG_PROT[2:0]];
    assign trigger_cfg    = regs_r[flash_i2c_pkg::REG_TRIG[2:0]];

    // output and state guards; byte framing guards follow further down
    ack_drive_a: assert property (@(posedge clk) disable iff (reset)
        state_r == flash_i2c_pkg::st_ack |-> sda_oe)
        else $error("acknowledge slot not driven low");
    idle_release_a: assert property (@(posedge clk) disable iff (reset)
        state_r == flash_i2c_pkg::st_idle |-> !sda_oe)
        else $error("data driven while idle");
    start_restart_a: assert property (@(posedge clk) disable iff (reset)
        ev.start |=> state_r == flash_i2c_pkg::st_rx && cnt_r == flash_i2c_pkg::CNT_ZERO
                     && phase_r == flash_i2c_pkg::ph_dev)
        else $error("start did not restart address reception");
    stop_release_a: assert property (@(posedge clk) disable iff (reset)
        ev.stop && !ev.start |=> !sda_oe && state_r == flash_i2c_pkg::st_idle)
        else $error("bus not released after stop");
    write_wrap_a: assert property (@(posedge clk) disable iff (reset)
        wr_fire && ptr_r == flash_i2c_pkg::WR_WRAP_LAST |=> ptr_r == flash_i2c_pkg::PTR_FIRST)
        else $error("write pointer did not wrap");
    write_step_a: assert property (@(posedge clk) disable iff (reset)
        wr_fire && ptr_r < flash_i2c_pkg::WR_WRAP_LAST |=> ptr_r == $past(ptr_r) + 5'h01)
        else $error("write pointer did not advance");
    read_wrap_a: assert property (@(posedge clk) disable iff (reset)
        tx_load && ptr_r == flash_i2c_pkg::RD_WRAP_LAST |=> ptr_r == flash_i2c_pkg::PTR_FIRST)
        else $error("read pointer did not wrap");
    locked_write_a: assert property (@(posedge clk) disable iff (reset)
        wr_fire && !unlocked && ptr_r != flash_i2c_pkg::REG_KEY |=> $stable(regs_r))
        else $error("locked register changed");
    sda_timing_a: assert property (@(posedge clk) disable iff (reset)
        $changed(sda_oe) |-> $past(ev.scl_fall || ev.start || ev.stop))
        else $error("data line changed outside clock low");
    power_map_a: assert property (@(posedge clk) disable iff (reset)
        power_down |-> regs_r[flash_i2c_pkg::REG_CHAN[2:0]][1:0] == 2'h0)
        else $error("power down with a channel enabled");

    // byte framing: address match, acknowledge, pointer load and read end
    addr_match_a: assert property (@(posedge clk) disable iff (reset)
        state_r == flash_i2c_pkg::st_rx && phase_r == flash_i2c_pkg::ph_dev && ev.scl_fall
        && cnt_r == flash_i2c_pkg::BITS_PER_BYTE && shift_r[7:1] == flash_i2c_pkg::DEV_ADDR
        |=> state_r == flash_i2c_pkg::st_ack && rw_r == shift_r[0])
        else $error("own address not taken");
    foreign_drop_a: assert property (@(posedge clk) disable iff (reset)
        state_r == flash_i2c_pkg::st_rx && phase_r == flash_i2c_pkg::ph_dev && ev.scl_fall
        && cnt_r == flash_i2c_pkg::BITS_PER_BYTE && shift_r[7:1] != flash_i2c_pkg::DEV_ADDR
        |=> state_r == flash_i2c_pkg::st_idle && !sda_oe)
        else $error("foreign address answered");
    data_ack_a: assert property (@(posedge clk) disable iff (reset)
        state_r == flash_i2c_pkg::st_rx && phase_r != flash_i2c_pkg::ph_dev && ev.scl_fall
        && cnt_r == flash_i2c_pkg::BITS_PER_BYTE |=> state_r == flash_i2c_pkg::st_ack && sda_oe)
        else $error("received byte not acknowledged");
    reg_load_a: assert property (@(posedge clk) disable iff (reset)
        state_r == flash_i2c_pkg::st_rx && phase_r == flash_i2c_pkg::ph_reg && ev.scl_fall
        && cnt_r == flash_i2c_pkg::BITS_PER_BYTE |=> ptr_r == 5'($past(shift_r)))
        else $error("register pointer not loaded");
    key_write_a: assert property (@(posedge clk) disable iff (reset)
        wr_fire && ptr_r == flash_i2c_pkg::REG_KEY
        |=> regs_r[flash_i2c_pkg::REG_KEY[2:0]] == $past(shift_r))
        else $error("key register write lost");
    nack_release_a: assert property (@(posedge clk) disable iff (reset)
        state_r == flash_i2c_pkg::st_mack && ev.scl_fall && !mack_r
        |=> state_r == flash_i2c_pkg::st_idle && !sda_oe)
        else $error("read not ended on master nack");
endmodule // flash_i2c_slave

// >>> i2c_host_model.sv
// behavioural two-wire bus master that stands on the far side of the slave
// assumes an open-drain data line with pull-up resolved by the bench
`timescale 1ns/1ps
module i2c_host_model #(
    parameter time QTR_NS = 40
) (
    // bus lines driven by the master
    output logic      scl,
    output logic      sda_low,
    // resolved data line
    input  wire logic sda
);
    // clock stands high and data released outside frames
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // one bit out; data moves only while the clock is low
    // line changes land on clk edges, so they go non-blocking to avoid a race
    task automatic bit_out(input logic b);
        sda_low <= !b;
        #QTR_NS scl <= 1'b1;
        #(2*QTR_NS) scl <= 1'b0;
        #QTR_NS;
    endtask

    // one bit in; line released so the slave can drive it
    task automatic bit_in(output logic b);
        sda_low <= 1'b0;
        #QTR_NS scl <= 1'b1;
        #QTR_NS b = sda;
        #QTR_NS scl <= 1'b0;
        #QTR_NS;
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_low <= 1'b0;
        #QTR_NS scl <= 1'b1;
        #QTR_NS sda_low <= 1'b1;
        #QTR_NS scl <= 1'b0;
        #QTR_NS;
    endtask

    // stop: data rises while the clock is high, then the bus idles
    task automatic stop();
        sda_low <= 1'b1;
        #QTR_NS scl <= 1'b1;
        #QTR_NS sda_low <= 1'b0;
        #QTR_NS;
    endtask

    // byte to the slave, msb first, then its acknowledge bit
    task automatic send(input logic [7:0] v, output logic nack);
        for (int i = 7; i >= 0; i--) bit_out(v[i]);
        bit_in(nack);
    endtask

    // byte from the slave; low ack asks for more, high ends the read
    task automatic recv(input logic ack, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) bit_in(v[i]);
        bit_out(!ack);
    endtask
endmodule // i2c_host_model

// >>> i2c_register_slave_tb_top.sv
// self-checking bench for the flash driver two-wire register slave
// assumes the host model in i2c_host_model.sv and the design package
`timescale 1ns/1ps
module i2c_register_slave_tb_top;
    localparam logic [6:0] own_addr = 7'h37;
    localparam logic [7:0] key      = 8'h69;
    logic       clk;
    logic       reset;
    logic [7:0] fault_status;
    logic       sda_oe, sda_o, ch1, ch2, pdn;
    logic [7:0] tcfg, ccfg, pcfg, trig, d;
    logic       host_low, ack_n, watch_foreign;
    logic       drove_foreign = 1'b0;
    wire logic  scl_line;
    wire logic  sda_line;
    integer     seed = 32'h3b9eca4c;
    int         fails = 0;
    int         checks = 0;
    logic [7:0] shadow [0:6];
    logic [7:0] q [$];

    // open-drain data line: pull-up unless someone pulls low
    assign sda_line = (host_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

    flash_i2c_slave u_dut (
        .clk(clk), .reset(reset), .scl_in(scl_line), .sda_in(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .fault_status(fault_status),
        .channel_one_on(ch1), .channel_two_on(ch2), .power_down(pdn),
        .timing_cfg(tcfg), .current_cfg(ccfg), .protect_cfg(pcfg), .trigger_cfg(trig));
    i2c_host_model u_host (.scl(scl_line), .sda_low(host_low), .sda(sda_line));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // any slave pull on the data line while a foreign transfer runs is a fault
    always @(posedge clk) if (watch_foreign && sda_oe) drove_foreign <= 1'b1;

    function automatic logic down_exp(input logic [7:0] c);
        return c[1:0] == 2'b00;
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic done(input string name);
        $display("test %0s done, %0d mismatches so far", name, fails);
    endtask

    task automatic outs_ok();
        check("channel one", {7'h00, ch1}, {7'h00, shadow[1][0]});
        check("channel two", {7'h00, ch2}, {7'h00, shadow[1][1]});
        check("power down", {7'h00, pdn}, {7'h00, down_exp(shadow[1])});
        check("timing cfg", tcfg, shadow[2]);
        check("current cfg", ccfg, shadow[3]);
        check("protect cfg", pcfg, shadow[4]);
        check("trigger cfg", trig, shadow[5]);
    endtask

    // start, own address with write direction, register pointer
    task automatic hdr(input logic [7:0] ptr);
        u_host.start();
        u_host.send({own_addr, 1'b0}, ack_n);
        check("address ack", {7'h00, ack_n}, 8'h00);
        u_host.send(ptr, ack_n);
        check("pointer ack", {7'h00, ack_n}, 8'h00);
    endtask

    // write the bytes of q from ptr on, tracking what should land
    task automatic wr(input logic [7:0] ptr);
        logic [4:0] p;
        p = ptr[4:0];
        hdr(ptr);
        foreach (q[i]) begin
            u_host.send(q[i], ack_n);
            check("data ack", {7'h00, ack_n}, 8'h00);
            if (p == 5'h00 || (p <= 5'h05 && shadow[0] == key)) shadow[p] = q[i];
            p = (p >= 5'h0b) ? 5'h00 : p + 5'h01;
        end
        u_host.stop();
        repeat (4) @(posedge clk);
        outs_ok();
    endtask

    // dummy write, repeated start, then n bytes read back
    task automatic rd(input logic [7:0] ptr, input int n);
        logic [4:0] p;
        p = ptr[4:0];
        hdr(ptr);
        u_host.start();
        u_host.send({own_addr, 1'b1}, ack_n);
        check("read address ack", {7'h00, ack_n}, 8'h00);
        for (int i = 0; i < n; i++) begin
            u_host.recv(i < n - 1, d);
            check("read data", d, (p <= 5'h06) ? shadow[p] : 8'h00);
            p = (p >= 5'h06) ? 5'h00 : p + 5'h01;
        end
        u_host.stop();
        repeat (4) @(posedge clk);
        check("line released", {7'h00, sda_oe}, 8'h00);
    endtask

    // hang guard well inside the cycle budget
    initial begin
        #700us;
        fails++;
        close_out();
    end

    initial begin
        reset = 1'b1;
        fault_status = 8'h00;
        watch_foreign = 1'b0;
        shadow = '{8'h00, 8'h00, 8'h07, 8'h0c, 8'h02, 8'h00, 8'h00};
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        outs_ok();
        done("reset values");
        // locked: channel write must not land before the key
        q = '{8'h03, 8'h55};
        wr(8'h01);
        done("locked write");
        q = '{key, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
              8'($random(seed)), 8'($random(seed))};
        wr(8'h00);
        for (int c = 0; c < 4; c++) begin
            q = '{8'(c)};
            wr(8'h01);
        end
        done("unlock and burst");
        // deliberately crosses 0x0a..0x0b to see the write wrap
        q = '{8'($random(seed)), 8'($random(seed)), key, 8'h03};
        wr(8'h0a);
        done("write wrap");
        u_host.start();
        u_host.send({own_addr, 1'b0}, ack_n);
        for (int i = 0; i < 4; i++) u_host.bit_out(1'b1);
        q = '{8'($random(seed))};
        wr(8'h02);
        done("abort mid-byte");
        @(posedge clk);
        fault_status <= 8'($random(seed));
        repeat (4) @(posedge clk);
        shadow[6] = fault_status;
        rd(8'h04, 6);
        rd(8'h09, 2);
        done("reads");
        watch_foreign = 1'b1;
        u_host.start();
        u_host.send({own_addr ^ 7'(1 + ($unsigned($random(seed)) % 127)), 1'b0}, ack_n);
        check("foreign nack", {7'h00, ack_n}, 8'h01);
        u_host.send(8'h00, ack_n);
        check("foreign byte nack", {7'h00, ack_n}, 8'h01);
        u_host.stop();
        watch_foreign = 1'b0;
        check("foreign silent", {7'h00, drove_foreign}, 8'h00);
        done("foreign address");
        for (int k = 0; k < 4; k++) begin
            q = {};
            repeat (1 + ($unsigned($random(seed)) % 3)) q.push_back(8'($random(seed)));
            wr(8'($unsigned($random(seed)) % 4));
            rd(8'h00, 7);
        end
        done("random bursts");
        close_out();
    end
endmodule // i2c_register_slave_tb_top
